//--- design/dpc_pkg.sv
// Constants and types for the DTE port configuration and control block.
// Assumes a 25 MHz system clock and a separate link clock that is passed on to the DTE.
// Notes on behaviour
// - Port rate equals slot count times rate multiple, 56 kbps to 1.536 Mbps.
// - Rate multiple is 56 or 64 kbps; NO swaps it while edited.
// - Editing slot count: NO increments it, YES moves to rate multiple.
// - Alternating and contiguous slot modes; NO at assignment swaps them.
// - Last channel is computed from first channel and slot count.
// - Editing first channel: NO increments start, YES accepts it.
// - Internal source: transmit data captured with own transmit clock.
// - External source: data clocked with clock looped back by the DTE.
// - Transmit clock polarity normal or inverted; YES goes to receive polarity.
// - Receive clock polarity normal or inverted; YES goes to CTS setting.
// - CTS follows RTS after about 10 ms, or is forced on.
// - RLSD follows T1 frame sync, or is forced on.
// - DSR follows T1 frame sync, or is forced on.
// - TM shows any test mode, or is forced off.
// - LL from DTE, when enabled, gives local terminal loopback.
// - RL from DTE, when enabled, gives remote terminal loopback.
// - Remote loop-up sequence, when enabled, gives remote terminal loopback.
// - Port select: YES enters port settings, NO steps to next port.
// - HOME from any per-port display returns to port select.
// - Accepting first channel goes to transmit clock source; NO swaps source.
package dpc_pkg;
  localparam int        NUM_CHANNELS = 24;
  localparam int        RATE_LO_KBPS = 56;
  localparam int        RATE_HI_KBPS = 64;
  localparam int        MAX_RATE_KBPS = 1536;
  localparam int        CLK_HZ = 25000000;
  localparam int        CTS_DELAY_MS = 10;
  localparam int        CTS_DELAY_CYC = CLK_HZ / 1000 * CTS_DELAY_MS;
  localparam logic [4:0] SLOT_CNT_RST = 5'h01;
  localparam logic [4:0] FIRST_CH_RST = 5'h01;
  localparam logic [1:0] PORT_RST = 2'h0;
  localparam int        NUM_PORTS = 2;

  typedef enum logic [3:0] {
    DPC_PORT_SEL,
    DPC_SLOT_CNT,
    DPC_RATE_MUL,
    DPC_ASSIGN,
    DPC_FIRST_CH,
    DPC_TX_SRC,
    DPC_TX_POL,
    DPC_RX_POL,
    DPC_CTS_MODE,
    DPC_RLSD_MODE,
    DPC_DSR_MODE,
    DPC_TM_MODE,
    DPC_LL_MODE,
    DPC_RL_MODE,
    DPC_RTL_MODE
  } dpc_menu_t;
endpackage

//--- design/dpc_port_ctrl.sv
// DTE port configuration menu, slot map and modem-control signals.
// Assumes debounced one-cycle button pulses on clk_sys and async DTE pins.
`timescale 1ns/1ps
module dpc_port_ctrl
  import dpc_pkg::*;
#(
  parameter int CTS_CYC = CTS_DELAY_CYC
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_link,
  input  wire logic        btn_yes,
  input  wire logic        btn_no,
  input  wire logic        btn_home,
  input  wire logic        frame_sync,
  input  wire logic        signal_present,
  input  wire logic        unit_test_mode,
  input  wire logic        loop_up_detect,
  input  wire logic        dte_rts,
  input  wire logic        dte_ll,
  input  wire logic        dte_rl,
  input  wire logic        dte_txd,
  input  wire logic        ext_clk_in,
  input  wire logic        net_rxd,
  output logic [3:0]       menu_state,
  output logic [1:0]       sel_port,
  output logic [4:0]       slot_count,
  output logic             rate_multiple_64,
  output logic [10:0]      port_rate_kbps,
  output logic             contiguous_slot_mode,
  output logic [4:0]       first_channel,
  output logic [4:0]       last_channel,
  output logic [23:0]      slot_map,
  output logic             tx_ext_src,
  output logic             tx_pol_inv,
  output logic             rx_pol_inv,
  output logic             dte_cts,
  output logic             dte_rlsd,
  output logic             dte_dsr,
  output logic             dte_tm,
  output logic             local_term_loop,
  output logic             remote_term_loop,
  output logic             tx_bit,
  output logic             tx_clk_out,
  output logic             rx_clk_out,
  output logic             dte_rxd
);
  localparam int CNT_W = $clog2(CTS_CYC + 1);

  dpc_menu_t        menu_ff;
  dpc_menu_t        nxt_menu;
  logic [1:0]       port_ff;
  logic [4:0]       slots_ff;
  logic             mul64_ff;
  logic             contiguous_slot_mode_ff;
  logic [4:0]       first_ff;
  logic             ext_ff;
  logic             txinv_ff;
  logic             rxinv_ff;
  logic             cts_force_ff;
  logic             rlsd_force_ff;
  logic             dsr_force_ff;
  logic             tm_off_ff;
  logic             ll_en_ff;
  logic             rl_en_ff;
  logic             rtl_en_ff;
  logic [CNT_W-1:0] cts_cnt_ff;
  logic             cts_ff;
  logic [2:0]       pins_s;
  logic             rts_s;
  logic             ll_s;
  logic             rl_s;
  logic [2:0]       cfg_link;
  logic             loop_link;
  logic [6:0]       span;
  logic [4:0]       last_ch;
  logic             edit;
  logic [4:0]       slot_max;

  assign edit = (menu_ff != DPC_PORT_SEL);

  // ****************************************************************
  // Menu walk
  // ****************************************************************
  always_comb
  begin
    nxt_menu = menu_ff;
    if (btn_home)
      nxt_menu = DPC_PORT_SEL;
    else if (btn_yes)
    begin
      case (menu_ff)
        DPC_PORT_SEL:  nxt_menu = DPC_SLOT_CNT;
        DPC_SLOT_CNT:  nxt_menu = DPC_RATE_MUL;
        DPC_RATE_MUL:  nxt_menu = DPC_ASSIGN;
        DPC_ASSIGN:    nxt_menu = DPC_FIRST_CH;
        DPC_FIRST_CH:  nxt_menu = DPC_TX_SRC;
        DPC_TX_SRC:    nxt_menu = DPC_TX_POL;
        DPC_TX_POL:    nxt_menu = DPC_RX_POL;
        DPC_RX_POL:    nxt_menu = DPC_CTS_MODE;
        DPC_CTS_MODE:  nxt_menu = DPC_RLSD_MODE;
        DPC_RLSD_MODE: nxt_menu = DPC_DSR_MODE;
        DPC_DSR_MODE:  nxt_menu = DPC_TM_MODE;
        DPC_TM_MODE:   nxt_menu = DPC_LL_MODE;
        DPC_LL_MODE:   nxt_menu = DPC_RL_MODE;
        DPC_RL_MODE:   nxt_menu = DPC_RTL_MODE;
        DPC_RTL_MODE:  nxt_menu = DPC_PORT_SEL;
        default:       nxt_menu = DPC_PORT_SEL;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      menu_ff <= DPC_PORT_SEL;
    else
      menu_ff <= nxt_menu;
  end

  // NO steps to the next port, nothing else changes.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      port_ff <= PORT_RST;
    else if (!btn_home && !btn_yes && btn_no && !edit)
      port_ff <= (port_ff == 2'(NUM_PORTS - 1)) ? 2'h0 : port_ff + 2'h1;
  end

  // ****************************************************************
  // Rate and slot settings
  // ****************************************************************
  // The slot count wraps so that the rate never exceeds the T1 payload.
  // Alternating groups need two channels per slot, so they stop at half.
  // Slot ceiling per mode.
  assign slot_max = contiguous_slot_mode_ff ? 5'(NUM_CHANNELS) : 5'(NUM_CHANNELS / 2);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      slots_ff <= SLOT_CNT_RST;
    else if (btn_no && !btn_yes && !btn_home && menu_ff == DPC_SLOT_CNT)
      slots_ff <= (slots_ff >= slot_max) ? 5'h01 : slots_ff + 5'h01;
    else if (btn_no && !btn_yes && !btn_home && menu_ff == DPC_ASSIGN
             && contiguous_slot_mode_ff && slots_ff > 5'(NUM_CHANNELS / 2))
      slots_ff <= 5'(NUM_CHANNELS / 2);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mul64_ff <= 1'b0;
    else if (btn_no && !btn_yes && !btn_home && menu_ff == DPC_RATE_MUL)
      mul64_ff <= ~mul64_ff;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      contiguous_slot_mode_ff <= 1'b0;
    else if (btn_no && !btn_yes && !btn_home && menu_ff == DPC_ASSIGN)
      contiguous_slot_mode_ff <= ~contiguous_slot_mode_ff;
  end

  // Span in channels covered by the group, first to last inclusive.
  // Spacing per mode.
  assign span = contiguous_slot_mode_ff ? {2'h0, slots_ff} : 7'({slots_ff, 1'b0} - 6'h01);

  // First channel wraps so the group ends by channel 24.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      first_ff <= FIRST_CH_RST;
    else if (7'(first_ff) + span - 7'h01 > 7'(NUM_CHANNELS))
      first_ff <= FIRST_CH_RST;
    else if (btn_no && !btn_yes && !btn_home && menu_ff == DPC_FIRST_CH)
    begin
      if (7'(first_ff) + span > 7'(NUM_CHANNELS))
        first_ff <= FIRST_CH_RST;
      else
        first_ff <= first_ff + 5'h01;
    end
  end

  assign last_ch = 5'(7'(first_ff) + span - 7'h01);

  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++)
    begin : g_slot
      logic [5:0] off;
      assign off = 6'(g + 1) - {1'b0, first_ff};
      assign slot_map[g] = (5'(g + 1) >= first_ff) && (5'(g + 1) <= last_ch)
                         && (contiguous_slot_mode_ff || !off[0]);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ext_ff <= 1'b0;
    else if (btn_no && !btn_yes && !btn_home && menu_ff == DPC_TX_SRC)
      ext_ff <= ~ext_ff;
  end

  // ****************************************************************
  // Toggle options
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txinv_ff      <= 1'b0;
      rxinv_ff      <= 1'b0;
      cts_force_ff  <= 1'b0;
      rlsd_force_ff <= 1'b0;
      dsr_force_ff  <= 1'b0;
      tm_off_ff     <= 1'b0;
      ll_en_ff      <= 1'b0;
      rl_en_ff      <= 1'b0;
      rtl_en_ff     <= 1'b0;
    end
    else if (btn_no && !btn_yes && !btn_home)
    begin
      case (menu_ff)
        DPC_TX_POL:    txinv_ff      <= ~txinv_ff;
        DPC_RX_POL:    rxinv_ff      <= ~rxinv_ff;
        DPC_CTS_MODE:  cts_force_ff  <= ~cts_force_ff;
        DPC_RLSD_MODE: rlsd_force_ff <= ~rlsd_force_ff;
        DPC_DSR_MODE:  dsr_force_ff  <= ~dsr_force_ff;
        DPC_TM_MODE:   tm_off_ff     <= ~tm_off_ff;
        DPC_LL_MODE:   ll_en_ff      <= ~ll_en_ff;
        DPC_RL_MODE:   rl_en_ff      <= ~rl_en_ff;
        DPC_RTL_MODE:  rtl_en_ff     <= ~rtl_en_ff;
        default:       txinv_ff      <= txinv_ff;
      endcase
    end
  end

  // ****************************************************************
  // Modem-control signals
  // ****************************************************************
  dpc_sync #(.WIDTH(3)) u_pin_sync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .din   ({dte_rts, dte_ll, dte_rl}),
    .dout  (pins_s)
  );
  assign rts_s = pins_s[2];
  assign ll_s  = pins_s[1];
  assign rl_s  = pins_s[0];

  // CTS delay counter; dropping RTS restarts it.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cts_cnt_ff <= '0;
      cts_ff     <= 1'b0;
    end
    else if (!rts_s)
    begin
      cts_cnt_ff <= '0;
      cts_ff     <= 1'b0;
    end
    else if (cts_cnt_ff == CNT_W'(CTS_CYC - 1))
      cts_ff <= 1'b1;
    else
      cts_cnt_ff <= cts_cnt_ff + CNT_W'(1);
  end

  assign dte_cts  = cts_force_ff | cts_ff;
  assign dte_rlsd = rlsd_force_ff | (frame_sync & signal_present);
  assign dte_dsr  = dsr_force_ff | (frame_sync & signal_present);
  assign dte_tm   = ~tm_off_ff & (unit_test_mode | local_term_loop
                                  | remote_term_loop);
  assign local_term_loop  = ll_en_ff & ll_s;
  assign remote_term_loop = (rl_en_ff & rl_s) | (rtl_en_ff & loop_up_detect);

  // ****************************************************************
  // Link side
  // ****************************************************************
  // Settings change only from the menu or the LL pin, so per-bit level sync is enough.
  dpc_sync #(.WIDTH(4)) u_cfg_sync (
    .clk   (clk_link),
    .rst_n (rst_n),
    .din   ({ext_ff, txinv_ff, rxinv_ff, local_term_loop}),
    .dout  ({cfg_link, loop_link})
  );

  dpc_tx_capture u_cap (
    .clk_link   (clk_link),
    .rst_n      (rst_n),
    .ext_src    (cfg_link[2]),
    .tx_pol_inv (cfg_link[1]),
    .rx_pol_inv (cfg_link[0]),
    .local_loop (loop_link),
    .ext_clk_in (ext_clk_in),
    .dte_txd    (dte_txd),
    .net_rxd    (net_rxd),
    .tx_bit_ff  (tx_bit),
    .tx_clk_out (tx_clk_out),
    .rx_clk_out (rx_clk_out),
    .dte_rxd_ff (dte_rxd)
  );

  assign port_rate_kbps = 11'(slots_ff * (mul64_ff ? RATE_HI_KBPS
                                                   : RATE_LO_KBPS));

  assign menu_state           = menu_ff;
  assign sel_port             = port_ff;
  assign slot_count           = slots_ff;
  assign rate_multiple_64     = mul64_ff;
  assign contiguous_slot_mode = contiguous_slot_mode_ff;
  assign first_channel        = first_ff;
  assign last_channel         = last_ch;
  assign tx_ext_src           = ext_ff;
  assign tx_pol_inv           = txinv_ff;
  assign rx_pol_inv           = rxinv_ff;
endmodule

//--- design/dpc_sync.sv
// Two-flop synchroniser, one per bit.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module dpc_sync
  import dpc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      dout    <= '0;
    end
    else
    begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule

//--- design/dpc_tx_capture.sv
// Link-side capture of DTE transmit data and the local loopback path.
// Runs on the link clock; configuration arrives already synchronised.
`timescale 1ns/1ps
module dpc_tx_capture
  import dpc_pkg::*;
(
  input  wire logic clk_link,
  input  wire logic rst_n,
  input  wire logic ext_src,
  input  wire logic tx_pol_inv,
  input  wire logic rx_pol_inv,
  input  wire logic local_loop,
  input  wire logic ext_clk_in,
  input  wire logic dte_txd,
  input  wire logic net_rxd,
  output logic      tx_bit_ff,
  output logic      tx_clk_out,
  output logic      rx_clk_out,
  output logic      dte_rxd_ff
);
  logic ext_bit_ff;

  // Transmit clock toward the DTE is the link clock, optionally inverted.
  assign tx_clk_out = clk_link ^ tx_pol_inv;
  assign rx_clk_out = clk_link ^ rx_pol_inv;

  // External mode clocks data with the clock the DTE returns.
  // The returned clock is our own link clock delayed by the cable, so it
  // can never be sampled by the link clock; it clocks its own flop.
  always_ff @(posedge ext_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      ext_bit_ff <= 1'b0;
    else
      ext_bit_ff <= dte_txd;
  end

  // Pick the captured bit per source.
  always_ff @(posedge clk_link or negedge rst_n)
  begin
    if (!rst_n)
      tx_bit_ff <= 1'b0;
    else
      tx_bit_ff <= ext_src ? ext_bit_ff : dte_txd;
  end

  // Local loop returns the DTE's own data.
  always_ff @(posedge clk_link or negedge rst_n)
  begin
    if (!rst_n)
      dte_rxd_ff <= 1'b1;
    else
      dte_rxd_ff <= local_loop ? dte_txd : net_rxd;
  end
endmodule

//--- tb/dpc_dte_model.sv
// Behavioural DTE on the synchronous serial port.
// Assumes the device's transmit clock output reaches it directly.
`timescale 1ns/1ps
module dpc_dte_model
(
  input  wire logic tx_clk_out,
  input  wire logic slow,
  output logic      ext_clk_in,
  output logic      dte_txd
);
  // ****************************************
  // Clock return and data source
  // ****************************************
  logic [7:0] lfsr_ff;
  logic [3:0] hold_ff;
  assign ext_clk_in = tx_clk_out;
  initial
  begin
    lfsr_ff = 8'h5A;
    hold_ff = 4'h0;
    dte_txd = 1'b1;
  end
  // Data beside clock
  // Data moves on the falling edge, away from the device's sampling edge.
  always @(negedge tx_clk_out)
  begin
    hold_ff <= (hold_ff == 4'h0) ? (slow ? 4'h7 : 4'h0) : hold_ff - 4'h1;
    if (hold_ff == 4'h0)
    begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[3]};
      dte_txd <= lfsr_ff[0];
    end
  end
endmodule

//--- tb/dpc_port_ctrl_properties.sv
// Concurrent checks on the ports of the port configuration block.
// Assumes one-cycle button pulses and levels sampled on clk_sys.
`timescale 1ns/1ps
module dpc_port_ctrl_properties
  import dpc_pkg::*;
#(
  parameter int CTS_CYC = CTS_DELAY_CYC
)
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        btn_yes,
  input wire logic        btn_no,
  input wire logic        btn_home,
  input wire logic        frame_sync,
  input wire logic        signal_present,
  input wire logic        dte_rts,
  input wire logic [3:0]  menu_state,
  input wire logic [1:0]  sel_port,
  input wire logic [4:0]  slot_count,
  input wire logic        rate_multiple_64,
  input wire logic [10:0] port_rate_kbps,
  input wire logic        contiguous_slot_mode,
  input wire logic [4:0]  first_channel,
  input wire logic [4:0]  last_channel,
  input wire logic        dte_cts,
  input wire logic        dte_rlsd,
  input wire logic        dte_dsr
);
  // ****************************************
  // Helper logic and assertions
  // ****************************************
  logic       no_only;
  logic       yes_only;
  logic [8:0] rts_hi_ff;
  assign no_only = btn_no & ~btn_yes & ~btn_home;
  assign yes_only = btn_yes & ~btn_home;
  // Saturates so that a long RTS does not wrap back below the delay.
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      rts_hi_ff <= 9'h000;
    else if (!dte_rts)
      rts_hi_ff <= 9'h000;
    else if (rts_hi_ff != 9'h1FF)
      rts_hi_ff <= rts_hi_ff + 9'h001;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_rate_product: assert property (
    int'(port_rate_kbps) == int'(slot_count) *
    (rate_multiple_64 ? RATE_HI_KBPS : RATE_LO_KBPS))
    else $error("port rate is not slots times multiple");
  a_rate_toggle: assert property (
    menu_state == 4'h2 && no_only |=> $changed(rate_multiple_64))
    else $error("rate multiple did not swap");
  a_slot_incr: assert property (
    menu_state == 4'h1 && no_only |=> slot_count ==
    (($past(slot_count) >= (contiguous_slot_mode ? 5'h18 : 5'h0C)) ? 5'h01
    : $past(slot_count) + 5'h01))
    else $error("slot count did not step");
  a_mode_swap: assert property (
    menu_state == 4'h3 && no_only |=> $changed(contiguous_slot_mode))
    else $error("slot mode did not swap");
  a_last_chan: assert property (
    int'(last_channel) == int'(first_channel) + (contiguous_slot_mode ?
    int'(slot_count) - 1 : 2 * int'(slot_count) - 2) &&
    last_channel <= 5'h18)
    else $error("last channel wrong");
  a_port_step: assert property (
    menu_state == 4'h0 && no_only |=> menu_state == 4'h0 &&
    $changed(sel_port))
    else $error("port did not step");
  a_home_return: assert property (
    btn_home && menu_state != 4'h0 |=> menu_state == 4'h0)
    else $error("home did not return");
  a_first_accept: assert property (
    menu_state == 4'h4 && yes_only |=> menu_state == 4'h5)
    else $error("first channel accept wrong");
  a_pol_advance: assert property (
    menu_state inside {4'h6, 4'h7} && yes_only |=>
    menu_state == $past(menu_state) + 4'h1)
    else $error("polarity display did not advance");
  a_carrier_on: assert property (
    frame_sync && signal_present |-> dte_rlsd && dte_dsr)
    else $error("carrier outputs low while in sync");
  a_cts_early: assert property (
    $rose(dte_cts) && dte_rts |-> int'(rts_hi_ff) >= CTS_CYC)
    else $error("clear to send came too early");
endmodule
bind dpc_port_ctrl dpc_port_ctrl_properties #(.CTS_CYC(CTS_CYC)) i_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .btn_yes(btn_yes), .btn_no(btn_no),
  .btn_home(btn_home), .frame_sync(frame_sync),
  .signal_present(signal_present), .dte_rts(dte_rts),
  .menu_state(menu_state), .sel_port(sel_port), .slot_count(slot_count),
  .rate_multiple_64(rate_multiple_64), .port_rate_kbps(port_rate_kbps),
  .contiguous_slot_mode(contiguous_slot_mode),
  .first_channel(first_channel), .last_channel(last_channel),
  .dte_cts(dte_cts), .dte_rlsd(dte_rlsd), .dte_dsr(dte_dsr));

//--- tb/tb.sv
// Self-checking bench for the port configuration and control block.
// Assumes the DTE model on the link and a free-running link clock.
`timescale 1ns/1ps
module tb;
  import dpc_pkg::*;
  localparam int CTS = 20;
  localparam logic [2:0] NO = 3'h1, YES = 3'h2, HOME = 3'h4;
  logic clk_sys, rst_n, clk_link, btn_yes, btn_no, btn_home, slow, prev;
  logic frame_sync, signal_present, unit_test_mode, loop_up_detect;
  logic dte_rts, dte_ll, dte_rl, dte_txd, ext_clk_in, net_rxd;
  logic [3:0] menu_state;
  logic [1:0] sel_port;
  logic [4:0] slot_count, first_channel, last_channel;
  logic [10:0] port_rate_kbps;
  logic [23:0] slot_map;
  logic rate_multiple_64, contiguous_slot_mode, tx_ext_src, tx_pol_inv;
  logic rx_pol_inv, dte_cts, dte_rlsd, dte_dsr, dte_tm, local_term_loop;
  logic remote_term_loop, tx_bit, tx_clk_out, rx_clk_out, dte_rxd;
  int miscompares, checked, s, f, cm, n, stab;
  logic [31:0] rs = 32'h000035A9;
  dpc_port_ctrl #(.CTS_CYC(CTS)) i_dpc_port_ctrl (.*);
  dpc_dte_model i_dpc_dte_model (.tx_clk_out(tx_clk_out), .slow(slow),
    .ext_clk_in(ext_clk_in), .dte_txd(dte_txd));
  // ****************************************
  // Clocks, helpers and expectations
  // ****************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    clk_link = 1'b0;
    #7;
    forever #62.5 clk_link = ~clk_link;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic int last_of(int fc, int sc, int c);
    return c ? fc + sc - 1 : fc + 2 * sc - 2;
  endfunction
  function automatic logic [23:0] map_of(int fc, int sc, int c);
    logic [23:0] m;
    m = '0;
    for (int i = 0; i < sc; i++) m[last_of(fc, i + 1, c) - 1] = 1'b1;
    return m;
  endfunction
  always @(negedge clk_link) net_rxd <= rnd() % 2;
  // Counts link edges over which the DTE data has not moved.
  always @(posedge clk_link)
  begin
    stab <= (dte_txd === prev) ? stab + 1 : 0;
    prev <= dte_txd;
  end
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask
  task automatic press(input logic [2:0] b);
    idle(1);
    {btn_home, btn_yes, btn_no} = b;
    idle(1);
    {btn_home, btn_yes, btn_no} = 3'h0;
  endtask
  task automatic link_chk(input int m);
    repeat (40)
    begin
      @(posedge clk_link);
      #1;
      if (stab >= m) chk("tx_bit", dte_txd, tx_bit);
    end
  endtask
  task automatic rxd_chk(input logic lp);
    repeat (8)
    begin
      @(posedge clk_link);
      #1;
      chk("rxd", lp ? dte_txd : net_rxd, dte_rxd);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #500000;
    miscompares++;
    end_sim;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {btn_yes, btn_no, btn_home, frame_sync, signal_present} = 5'h00;
    {unit_test_mode, loop_up_detect, dte_rts, dte_ll, dte_rl} = 5'h00;
    {net_rxd, slow, rst_n, prev} = 4'h0;
    idle(5);
    rst_n = 1'b1;
    chk("reset", {4'h0, 2'h0, 5'h01, 2'h0, 5'h01, 4'h0}, {menu_state,
      sel_port, slot_count, rate_multiple_64, contiguous_slot_mode,
      first_channel, tx_ext_src, tx_pol_inv, rx_pol_inv, dte_cts});
    press(NO);
    chk("port", {4'h0, 2'h1}, {menu_state, sel_port});
    press(NO);
    press(YES);
    chk("port", {4'h1, 2'h0}, {menu_state, sel_port});
    repeat (24) press(NO);
    s = 1 + rnd() % 12;
    repeat (s - 1) press(NO);
    chk("slots", s, slot_count);
    chk("rate", s * 56, port_rate_kbps);
    press(YES);
    press(NO);
    chk("rate", s * 64, port_rate_kbps);
    press(YES);
    press(NO);
    chk("last", s, last_channel);
    cm = rnd() % 2;
    if (cm == 0) press(NO);
    chk("mode", cm, contiguous_slot_mode);
    press(YES);
    f = 1;
    repeat (rnd() % 30)
    begin
      press(NO);
      f = (last_of(f + 1, s, cm) > 24) ? 1 : f + 1;
      chk("first", f, first_channel);
      chk("last", last_of(f, s, cm), last_channel);
      chk("map", map_of(f, s, cm), slot_map);
    end
    press(YES);
    chk("menu", 4'h5, menu_state);
    link_chk(0);
    press(NO);
    chk("src", 1'h1, tx_ext_src);
    slow = 1'b1;
    idle(40);
    link_chk(5);
    press(NO);
    slow = 1'b0;
    press(YES);
    for (int st = 6; st < 8; st++)
    begin
      press(NO);
      chk("pol", 1'h1, st == 6 ? tx_pol_inv : rx_pol_inv);
      press(NO);
      press(YES);
      chk("menu", st + 1, menu_state);
    end
    dte_rts = 1'b1;
    n = 0;
    while (dte_cts !== 1'b1 && n < 100)
    begin
      idle(1);
      n++;
    end
    chk("cts_delay", 1'h1, n >= CTS && n <= CTS + 4);
    dte_rts = 1'b0;
    idle(4);
    chk("cts", 1'h0, dte_cts);
    press(NO);
    idle(2);
    chk("cts", 1'h1, dte_cts);
    press(NO);
    press(YES);
    for (int st = 9; st < 11; st++)
    begin
      repeat (4)
      begin
        {frame_sync, signal_present} = 2'(rnd() % 4);
        idle(2);
        chk("carrier", frame_sync & signal_present,
            st == 9 ? dte_rlsd : dte_dsr);
      end
      frame_sync = 1'b0;
      press(NO);
      idle(2);
      chk("forced", 1'h1, st == 9 ? dte_rlsd : dte_dsr);
      press(NO);
      press(YES);
    end
    unit_test_mode = 1'b1;
    idle(2);
    chk("tm", 1'h1, dte_tm);
    press(NO);
    chk("tm", 1'h0, dte_tm);
    press(NO);
    unit_test_mode = 1'b0;
    press(YES);
    dte_ll = 1'b1;
    idle(4);
    chk("ll", 1'h0, local_term_loop);
    rxd_chk(1'b0);
    press(NO);
    idle(4);
    chk("ll", 1'h1, local_term_loop);
    idle(12);
    rxd_chk(1'b1);
    press(NO);
    dte_ll = 1'b0;
    press(YES);
    dte_rl = 1'b1;
    idle(4);
    chk("rl", 1'h0, remote_term_loop);
    press(NO);
    idle(4);
    chk("rl", 1'h1, remote_term_loop);
    press(NO);
    dte_rl = 1'b0;
    press(YES);
    loop_up_detect = 1'b1;
    idle(2);
    chk("rtl", 1'h0, remote_term_loop);
    press(NO);
    idle(2);
    chk("rtl", 1'h1, remote_term_loop);
    press(HOME);
    chk("menu", 4'h0, menu_state);
    press(YES);
    press(HOME | YES);
    chk("menu", 4'h0, menu_state);
    end_sim;
  end
endmodule
